// >>> hw/prio_defs.vh
`ifndef PRIO_DEFS_VH
`define PRIO_DEFS_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define PRIO_CLK_PERIOD_NS 4
// Contact settle time: a least time, so the cycle count rounds up.
`define PRIO_DEB_TIME_NS 1000000
`define PRIO_DEB_CYCLES ((`PRIO_DEB_TIME_NS + `PRIO_CLK_PERIOD_NS - 1) / `PRIO_CLK_PERIOD_NS)
`define PRIO_DEB_CNT_W 18
// One second of vent-valve timebase.
`define PRIO_SEC_NS 1000000000
`define PRIO_SEC_CYCLES (`PRIO_SEC_NS / `PRIO_CLK_PERIOD_NS)
`define PRIO_SEC_CNT_W 28
// Vent running time is programmed in steps of this many seconds.
`define PRIO_VENT_STEP_S 3'h5
`define PRIO_VENT_STEP_W 7
`define PRIO_PCT_W 7

// ----------------------------------------------------------------------------
// Command source encoding
// ----------------------------------------------------------------------------
`define PRIO_SRC_W 3
`define PRIO_SRC_CONTACT 3'h0
`define PRIO_SRC_CHAN_LAST 3'h4
`define PRIO_NUM_CHAN 4

// ----------------------------------------------------------------------------
// Contact input vector layout
// ----------------------------------------------------------------------------
`define PRIO_NUM_IN 7
`define PRIO_IN_OVERRIDE 0
`define PRIO_IN_START 1
`define PRIO_IN_STOP 2
`define PRIO_IN_FRESET 3
`define PRIO_IN_BLOCK 4
`define PRIO_IN_BLOCK_ARM 5
`define PRIO_IN_VENT_ARM 6

// ----------------------------------------------------------------------------
// Relay reset positions
// ----------------------------------------------------------------------------
`define PRIO_NO_RESET 1'b0
`define PRIO_NC_RESET 1'b1

`endif

// >>> hw/prio_debounce.v
`timescale 1ns/10ps
`include "prio_defs.vh"
module prio_debounce
#(
  parameter WIDTH = `PRIO_NUM_IN,
  parameter CNT_W = `PRIO_DEB_CNT_W,
  parameter [31:0] DEB_CYCLES = `PRIO_DEB_CYCLES
)
(
  input wire ref_clk, // system clock
  input wire nrst, // asynchronous reset, active low
  input wire [WIDTH-1:0] raw, // contact levels, 1 = closed
  output wire [WIDTH-1:0] clean // settled contact levels
);

  localparam [CNT_W-1:0] DEB_LAST = DEB_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_q;
      reg sync_q;
      reg out_q;
      reg [CNT_W-1:0] cnt_q;
      // A level only passes once it has held for the full settle time.
      always @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          out_q <= 1'b0;
          cnt_q <= {CNT_W{1'b0}};
        end
        else
        begin
          meta_q <= raw[i];
          sync_q <= meta_q;
          if (sync_q == out_q)
            cnt_q <= {CNT_W{1'b0}};
          else if (cnt_q == DEB_LAST)
          begin
            out_q <= sync_q;
            cnt_q <= {CNT_W{1'b0}};
          end
          else
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      assign clean[i] = out_q;
    end
  endgenerate

endmodule

// >>> hw/prio_vent_timer.v
`timescale 1ns/10ps
`include "prio_defs.vh"
module prio_vent_timer
#(
  parameter [31:0] SEC_CYCLES = `PRIO_SEC_CYCLES
)
(
  input wire ref_clk, // system clock
  input wire nrst, // asynchronous reset, active low
  input wire trigger, // one-cycle request to open the valve
  input wire cancel, // close the valve at once
  input wire [`PRIO_VENT_STEP_W-1:0] steps, // running time in 5 s steps
  output wire valve // vent valve drive, 1 = open
);

  localparam [`PRIO_SEC_CNT_W-1:0] SEC_LAST =
    SEC_CYCLES[`PRIO_SEC_CNT_W-1:0] - {{(`PRIO_SEC_CNT_W-1){1'b0}}, 1'b1};
  localparam [2:0] STEP_LAST = `PRIO_VENT_STEP_S - 3'h1;

  reg valve_q;
  reg [`PRIO_SEC_CNT_W-1:0] sec_cnt_q;
  reg [2:0] step_sec_q;
  reg [`PRIO_VENT_STEP_W-1:0] left_q;

  wire sec_tick = (sec_cnt_q == SEC_LAST);
  wire step_tick = sec_tick && (step_sec_q == STEP_LAST);

  // A zero running time is ignored rather than opening the valve forever.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      valve_q <= 1'b0;
      sec_cnt_q <= {`PRIO_SEC_CNT_W{1'b0}};
      step_sec_q <= 3'h0;
      left_q <= {`PRIO_VENT_STEP_W{1'b0}};
    end
    else if (cancel)
      valve_q <= 1'b0;
    else if (!valve_q)
    begin
      sec_cnt_q <= {`PRIO_SEC_CNT_W{1'b0}};
      step_sec_q <= 3'h0;
      left_q <= steps;
      if (trigger && (steps != {`PRIO_VENT_STEP_W{1'b0}}))
        valve_q <= 1'b1;
    end
    else
    begin
      sec_cnt_q <= sec_tick ? {`PRIO_SEC_CNT_W{1'b0}} :
                   sec_cnt_q + {{(`PRIO_SEC_CNT_W-1){1'b0}}, 1'b1};
      if (sec_tick)
        step_sec_q <= (step_sec_q == STEP_LAST) ? 3'h0 : step_sec_q + 3'h1;
      if (step_tick)
      begin
        left_q <= left_q - {{(`PRIO_VENT_STEP_W-1){1'b0}}, 1'b1};
        if (left_q == {{(`PRIO_VENT_STEP_W-1){1'b0}}, 1'b1})
          valve_q <= 1'b0;
      end
    end
  end

  assign valve = valve_q;

endmodule

// >>> hw/prio_remote_io.v
// Operation
// R01: Override input closed forces contact port; serial commands are ignored.
// R02: Override open: command source follows setting, contact port or four channels.
// R03: After reset the command source setting selects the contact port.
// R04: Interlock acts only while armed; arm input works under serial source too.
// R05: Vent arm closed drives vent valve during deceleration per stored settings.
// R06: Armed with block input closed, start accelerates the pump normally.
// R07: Armed with block input open, start is held and pump does not rotate.
// R08: Held start begins acceleration once block input closes, no new start.
// R09: Block input opening while running armed forces deceleration to stop.
// R10: Re-closing block input after such a stop does not restart the pump.
// R11: After a block stop, a fresh start accelerates again if block closed.
// R12: Status relays work whatever the command source is.
// R13: Levitation contact closes when levitated, opens on supply loss.
// R14: Speedup contact closed exactly in acceleration state.
// R15: Rated contacts: NO closed and NC open only in rated state.
// R16: Braking contact closed exactly in brake state.
// R17: Any abnormality closes NO fault contact and opens NC fault contact.
// R18: Alert contact closed exactly in warning state.
// R19: Port-active output closed exactly when contact port is effective source.
// R20: Start, stop, fault-reset contacts act only when contact port is source.
// R21: Pulse mode: equipment holds stop closed and start closed at least 0.3 s.
// R22: Level mode: pump runs while start closed, stops when start opens.
// R23: Every contact input is synchronized and debounced before use.
// R24: After reset all relays sit inactive, normally-closed contacts closed.
`timescale 1ns/10ps
`include "prio_defs.vh"
module prio_remote_io
#(
  parameter [31:0] DEB_CYCLES = `PRIO_DEB_CYCLES,
  parameter [31:0] SEC_CYCLES = `PRIO_SEC_CYCLES
)
(
  input wire ref_clk, // system clock, 250 MHz
  input wire nrst, // asynchronous reset, active low
  input wire port_override_in, // source override contact, 1 = closed
  input wire start_in, // start contact, 1 = closed
  input wire stop_in, // stop contact, 1 = closed
  input wire fault_reset_in, // fault reset contact, 1 = closed
  input wire block_in, // rotation block contact, 1 = closed
  input wire block_arm_in, // rotation block arm contact, 1 = closed
  input wire vent_arm_in, // vent valve arm contact, 1 = closed
  input wire [`PRIO_SRC_W-1:0] cmd_source, // 0 contact, 1..4 serial channel
  input wire start_level_mode, // 1 = level start, 0 = pulse start
  input wire [`PRIO_NUM_CHAN-1:0] serial_start, // start pulse per channel
  input wire [`PRIO_NUM_CHAN-1:0] serial_stop, // stop pulse per channel
  input wire [`PRIO_NUM_CHAN-1:0] serial_fault_reset, // fault reset pulse
  input wire levitated, // bearing working and rotor levitated
  input wire supply_ok, // supply power present
  input wire speed_rated, // rotor at rated speed
  input wire speed_zero, // rotor at standstill
  input wire [`PRIO_PCT_W-1:0] speed_pct, // rotor speed in percent of rated
  input wire fault_det, // abnormality detected, level
  input wire warning_det, // warning condition present, level
  input wire [`PRIO_PCT_W-1:0] vent_start_pct, // vent starting speed setting
  input wire [`PRIO_VENT_STEP_W-1:0] vent_time_steps, // vent time in 5 s steps
  output wire motor_drive, // 1 = drive rotor up or hold speed
  output wire brake_drive, // 1 = decelerate rotor
  output wire rotation_hold, // 1 = interlock holds rotor
  output wire [1:0] run_state, // run state code
  output wire start_pending, // start accepted, waiting or in progress
  output wire fault_latched, // abnormality latched until reset
  output wire relay_levitate, // levitation-ok contact
  output wire relay_speedup, // speedup contact
  output wire relay_rated_no, // rated speed, normally open
  output wire relay_rated_nc, // rated speed, normally closed
  output wire relay_brake, // braking contact
  output wire relay_fault_no, // fault, normally open
  output wire relay_fault_nc, // fault, normally closed
  output wire relay_alert, // warning contact
  output wire relay_port_active, // contact port is command source
  output wire vent_valve // vent valve drive
);

  // --------------------------------------------------------------------------
  // Run states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ACCEL = 2'h1;
  localparam [1:0] ST_RATED = 2'h2;
  localparam [1:0] ST_DECEL = 2'h3;

  // --------------------------------------------------------------------------
  // Channel select
  // --------------------------------------------------------------------------
  // Picks the command pulse of the selected serial channel; codes 1..4 map to
  // bit 0..3.
  function chan_pick;
    input [`PRIO_NUM_CHAN-1:0] vec;
    input [`PRIO_SRC_W-1:0] src;
    begin
      case (src)
        3'h1: chan_pick = vec[0];
        3'h2: chan_pick = vec[1];
        3'h3: chan_pick = vec[2];
        3'h4: chan_pick = vec[3];
        default: chan_pick = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Contact conditioning
  // --------------------------------------------------------------------------
  wire [`PRIO_NUM_IN-1:0] raw_in;
  wire [`PRIO_NUM_IN-1:0] deb_in;

  assign raw_in[`PRIO_IN_OVERRIDE] = port_override_in;
  assign raw_in[`PRIO_IN_START] = start_in;
  assign raw_in[`PRIO_IN_STOP] = stop_in;
  assign raw_in[`PRIO_IN_FRESET] = fault_reset_in;
  assign raw_in[`PRIO_IN_BLOCK] = block_in;
  assign raw_in[`PRIO_IN_BLOCK_ARM] = block_arm_in;
  assign raw_in[`PRIO_IN_VENT_ARM] = vent_arm_in;

  // Bouncing relay contacts would otherwise give double starts.
  prio_debounce
  #(
    .WIDTH(`PRIO_NUM_IN),
    .CNT_W(`PRIO_DEB_CNT_W),
    .DEB_CYCLES(DEB_CYCLES)
  )
  u_debounce
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .raw(raw_in),
    .clean(deb_in)
  ); // R23

  wire ovr_c = deb_in[`PRIO_IN_OVERRIDE];
  wire start_c = deb_in[`PRIO_IN_START];
  wire stop_c = deb_in[`PRIO_IN_STOP];
  wire freset_c = deb_in[`PRIO_IN_FRESET];
  wire block_c = deb_in[`PRIO_IN_BLOCK];
  wire arm_c = deb_in[`PRIO_IN_BLOCK_ARM];
  wire vent_arm_c = deb_in[`PRIO_IN_VENT_ARM];

  // Edge memory of the settled start and reset contacts.
  reg start_prev_q;
  reg freset_prev_q;

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      start_prev_q <= 1'b0;
      freset_prev_q <= 1'b0;
    end
    else
    begin
      start_prev_q <= start_c;
      freset_prev_q <= freset_c;
    end
  end

  wire start_rise = start_c && !start_prev_q;
  wire freset_rise = freset_c && !freset_prev_q;

  // --------------------------------------------------------------------------
  // Command source
  // --------------------------------------------------------------------------
  // An out-of-range setting falls back to the contact port so the pump is
  // never left without any controlling source.
  wire src_serial = (cmd_source != `PRIO_SRC_CONTACT) &&
                    (cmd_source <= `PRIO_SRC_CHAN_LAST); // R02 R03
  wire use_contact = ovr_c || !src_serial; // R01 R02
  wire use_serial = !use_contact; // R01

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  reg cont_start;
  reg cont_stop;

  // Pulse mode needs stop held closed; level mode runs on the start level.
  always @*
  begin
    if (start_level_mode)
    begin
      cont_start = start_rise; // R22
      cont_stop = !start_c; // R22
    end
    else
    begin
      cont_start = start_rise && stop_c; // R21
      cont_stop = !stop_c; // R21
    end
  end

  wire start_ev = (use_contact && cont_start) ||
                  (use_serial && chan_pick(serial_start, cmd_source)); // R20
  wire stop_ev = (use_contact && cont_stop) ||
                 (use_serial && chan_pick(serial_stop, cmd_source)); // R20
  wire freset_ev = (use_contact && freset_rise) ||
                   (use_serial && chan_pick(serial_fault_reset, cmd_source)); // R20

  // --------------------------------------------------------------------------
  // Interlock
  // --------------------------------------------------------------------------
  // The arm contact is read whatever the source is.
  wire blocked = arm_c && !block_c; // R04

  // --------------------------------------------------------------------------
  // Fault latch
  // --------------------------------------------------------------------------
  reg fault_q;

  // A fault present in the reset cycle stays latched.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      fault_q <= 1'b0;
    else if (fault_det)
      fault_q <= 1'b1; // R17
    else if (freset_ev)
      fault_q <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Run state machine
  // --------------------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg pend_q;
  reg pend_d;

  wire halt = fault_q || fault_det;

  always @*
  begin
    state_d = state_q;
    pend_d = pend_q;
    if (start_ev && !halt)
      pend_d = 1'b1; // R07
    case (state_q)
      ST_IDLE:
      begin
        // A held start waits here for the block contact to close.
        if (pend_q && !blocked && !halt)
          state_d = ST_ACCEL; // R06 R08
      end
      ST_ACCEL:
      begin
        if (halt || stop_ev || blocked)
          state_d = ST_DECEL; // R09
        else if (speed_rated)
          state_d = ST_RATED;
      end
      ST_RATED:
      begin
        if (halt || stop_ev || blocked)
          state_d = ST_DECEL; // R09
        else if (!speed_rated)
          state_d = ST_ACCEL;
      end
      ST_DECEL:
      begin
        // Only a fresh start leaves deceleration early.
        if (start_ev && !blocked && !halt)
          state_d = ST_ACCEL; // R10 R11
        else if (speed_zero)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    // A start issued in the same cycle as a stop loses, for safety, except in ST_DECEL, where the start still moves to ST_ACCEL.
    if (stop_ev || halt)
      pend_d = 1'b0;
    else if ((state_q != ST_IDLE) && (state_d == ST_DECEL))
      pend_d = 1'b0; // R10
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      pend_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pend_q <= pend_d;
    end
  end

  // --------------------------------------------------------------------------
  // Vent valve
  // --------------------------------------------------------------------------
  reg vent_done_q;

  // One opening per deceleration; leaving deceleration rearms it.
  wire vent_trig = (state_q == ST_DECEL) && vent_arm_c && !vent_done_q &&
                   (speed_pct <= vent_start_pct); // R05
  wire vent_cancel = (state_q == ST_ACCEL) || !vent_arm_c;

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      vent_done_q <= 1'b0;
    else if (state_q != ST_DECEL)
      vent_done_q <= 1'b0;
    else if (vent_trig)
      vent_done_q <= 1'b1;
  end

  prio_vent_timer
  #(
    .SEC_CYCLES(SEC_CYCLES)
  )
  u_vent
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .trigger(vent_trig),
    .cancel(vent_cancel),
    .steps(vent_time_steps),
    .valve(vent_valve)
  ); // R05

  // --------------------------------------------------------------------------
  // Relay and drive outputs
  // --------------------------------------------------------------------------
  reg levitate_q;
  reg speedup_q;
  reg rated_no_q;
  reg rated_nc_q;
  reg brake_q;
  reg fault_no_q;
  reg fault_nc_q;
  reg alert_q;
  reg port_act_q;
  reg motor_q;
  reg hold_q;

  // Outputs follow the next state so they line up with state_q.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      levitate_q <= `PRIO_NO_RESET; // R24
      speedup_q <= `PRIO_NO_RESET;
      rated_no_q <= `PRIO_NO_RESET;
      rated_nc_q <= `PRIO_NC_RESET; // R24
      brake_q <= `PRIO_NO_RESET;
      fault_no_q <= `PRIO_NO_RESET;
      fault_nc_q <= `PRIO_NC_RESET; // R24
      alert_q <= `PRIO_NO_RESET;
      port_act_q <= `PRIO_NO_RESET;
      motor_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      // None of these but port_act_q looks at the command source.
      levitate_q <= levitated && supply_ok; // R12 R13
      speedup_q <= (state_d == ST_ACCEL); // R14
      rated_no_q <= (state_d == ST_RATED); // R15
      rated_nc_q <= (state_d != ST_RATED); // R15
      brake_q <= (state_d == ST_DECEL); // R16
      fault_no_q <= fault_det || fault_q; // R17
      fault_nc_q <= !(fault_det || fault_q); // R17
      alert_q <= warning_det; // R18
      port_act_q <= use_contact; // R19
      motor_q <= (state_d == ST_ACCEL) || (state_d == ST_RATED);
      hold_q <= blocked; // R07
    end
  end

  assign motor_drive = motor_q;
  assign brake_drive = brake_q;
  assign rotation_hold = hold_q;
  assign run_state = state_q;
  assign start_pending = pend_q;
  assign fault_latched = fault_q;
  assign relay_levitate = levitate_q;
  assign relay_speedup = speedup_q;
  assign relay_rated_no = rated_no_q;
  assign relay_rated_nc = rated_nc_q;
  assign relay_brake = brake_q;
  assign relay_fault_no = fault_no_q;
  assign relay_fault_nc = fault_nc_q;
  assign relay_alert = alert_q;
  assign relay_port_active = port_act_q;

endmodule

// >>> verification/prio_remote_io_checker.sv
`timescale 1ns/10ps
module prio_remote_io_checker
(
  input wire ref_clk, // clock
  input wire nrst, // reset
  input wire [2:0] cmd_source, // source
  input wire [3:0] serial_start, // starts
  input wire [3:0] serial_stop, // stops
  input wire fault_det, // fault
  input wire warning_det, // warning
  input wire levitated, // levitated
  input wire supply_ok, // supply
  input wire fault_latched, // latch
  input wire [1:0] run_state, // state
  input wire start_pending, // pending
  input wire motor_drive, // drive
  input wire rotation_hold, // hold
  input wire relay_levitate, // relay
  input wire relay_speedup, // relay
  input wire relay_rated_no, // relay
  input wire relay_rated_nc, // relay
  input wire relay_brake, // relay
  input wire relay_fault_no, // relay
  input wire relay_fault_nc, // relay
  input wire relay_alert, // relay
  input wire relay_port_active // relay
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence idle_ready;
    run_state == 2'h0 && !start_pending && !fault_det && !fault_latched && !rotation_hold;
  endsequence
  sequence serial_go;
    !relay_port_active && $stable(cmd_source) && cmd_source == 3'h1
      && serial_start == 4'h1 && serial_stop == 4'h0;
  endsequence
  sequence running;
    !rotation_hold && (run_state == 2'h1 || run_state == 2'h2);
  endsequence

  speedup_state_a: assert property (relay_speedup == (run_state == 2'h1))
    else $error("speedup relay disagrees with state");
  rated_pair_a: assert property (relay_rated_no == (run_state == 2'h2)
    && relay_rated_nc == !relay_rated_no) else $error("rated relays wrong");
  brake_state_a: assert property (relay_brake == (run_state == 2'h3))
    else $error("brake relay disagrees with state");
  fault_relay_a: assert property (fault_det |=> relay_fault_no && !relay_fault_nc)
    else $error("fault relays did not switch");
  alert_follow_a: assert property ($past(nrst) |-> relay_alert == $past(warning_det))
    else $error("alert relay does not follow warning");
  levitate_follow_a: assert property ($past(nrst)
    |-> relay_levitate == $past(levitated && supply_ok)) else $error("levitate relay wrong");
  port_active_a: assert property ((cmd_source == 3'h0) [*3] |-> relay_port_active)
    else $error("contact port not reported active");
  hold_blocks_a: assert property (rotation_hold [*3] |-> !motor_drive)
    else $error("rotor driven while held");
  block_stop_a: assert property (running ##1 rotation_hold |-> run_state == 2'h3)
    else $error("no deceleration on block");
  serial_take_a: assert property (idle_ready ##0 serial_go
    |=> start_pending ##1 run_state == 2'h1) else $error("serial start not taken");
endmodule

bind prio_remote_io prio_remote_io_checker prio_remote_io_checker_i (.*);

// >>> verification/prio_contact_equip.sv
`timescale 1ns/10ps
module prio_contact_equip
(
  input wire ref_clk, // system clock
  input wire [6:0] want, // requested contact levels
  output reg [6:0] contact // levels seen at the device pins
);
  reg [6:0] goal_q = 7'h00;
  reg [6:0] diff_q = 7'h00;
  reg [2:0] chatter_q = 3'h0;
  initial contact = 7'h00;
  // Real contacts chatter before they settle, so each change bounces back to the old level
  // twice; a request made while chattering waits until the contact is quiet.
  always @(negedge ref_clk)
  begin
    if (chatter_q != 3'h0)
    begin
      chatter_q <= chatter_q - 3'h1;
      contact <= (chatter_q == 3'h1) ? goal_q : contact ^ diff_q;
    end
    else if (want != goal_q)
    begin
      diff_q <= want ^ goal_q;
      goal_q <= want;
      contact <= want;
      chatter_q <= 3'h4;
    end
  end
endmodule

// >>> verification/prio_remote_io_tb_top.sv
`timescale 1ns/10ps
module prio_remote_io_tb_top;
  reg ref_clk = 1'b0, nrst = 1'b0, start_level_mode = 1'b0, levitated = 1'b0;
  reg supply_ok = 1'b0, speed_rated = 1'b0, speed_zero = 1'b0;
  reg fault_det = 1'b0, warning_det = 1'b0;
  reg [2:0] cmd_source = 3'h0;
  reg [3:0] serial_start = 4'h0, serial_stop = 4'h0, serial_fault_reset = 4'h0;
  reg [6:0] speed_pct = 7'h0a, vent_start_pct = 7'h32, vent_time_steps = 7'h01;
  reg [6:0] want = 7'h00;
  reg [31:0] r;
  integer seed = 38, mismatches = 0, samples_checked = 0, i, n;
  wire [6:0] contact;
  wire port_override_in = contact[0], start_in = contact[1], stop_in = contact[2];
  wire fault_reset_in = contact[3], block_in = contact[4], block_arm_in = contact[5];
  wire vent_arm_in = contact[6];
  wire motor_drive, brake_drive, rotation_hold, start_pending, fault_latched, vent_valve;
  wire [1:0] run_state;
  wire relay_levitate, relay_speedup, relay_rated_no, relay_rated_nc, relay_brake;
  wire relay_fault_no, relay_fault_nc, relay_alert, relay_port_active;

  prio_remote_io #(.DEB_CYCLES(32'h4), .SEC_CYCLES(32'ha)) prio_remote_io_i (.*);
  prio_contact_equip prio_contact_equip_i (.ref_clk(ref_clk), .want(want), .contact(contact));

  always #2 ref_clk = ~ref_clk;

  always @(negedge ref_clk)
  begin
    r = $random(seed);
    warning_det <= r[0];
    levitated <= r[1];
    supply_ok <= r[2];
  end

  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task tick(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask

  task wait_st(input [1:0] s);
    begin
      n = 0;
      while (run_state !== s && n < 300)
      begin
        tick(1);
        n = n + 1;
      end
    end
  endtask

  task ser(input [1:0] kind, input [2:0] ch);
    reg [3:0] sel;
    begin
      sel = 4'h1 << (ch - 3'h1);
      serial_start <= (kind == 2'h0) ? sel : 4'h0;
      serial_stop <= (kind == 2'h1) ? sel : 4'h0;
      serial_fault_reset <= (kind == 2'h2) ? sel : 4'h0;
      tick(1);
      serial_start <= 4'h0;
      serial_stop <= 4'h0;
      serial_fault_reset <= 4'h0;
    end
  endtask

  task to_idle;
    begin
      speed_zero <= 1'b1;
      wait_st(2'h0);
      tick(1);
      speed_zero <= 1'b0;
    end
  endtask

  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // The whole run needs a few hundred cycles; this bound of 25000 cycles is far beyond it.
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    give_verdict;
  end

  initial
  begin
    tick(3);
    chk({relay_speedup, relay_rated_no, relay_rated_nc, relay_brake, relay_fault_no,
      relay_fault_nc, relay_port_active, vent_valve}, 8'h24);
    nrst <= 1'b1;
    tick(2);
    chk(relay_port_active, 1'b1);
    $display("reset test done");
    want[6] <= 1'b1;
    // The vent arm contact must have settled before the first deceleration.
    tick(20);
    for (i = 1; i <= 4; i = i + 1)
    begin
      cmd_source <= i[2:0];
      tick(2 + {$random(seed)} % 4);
      chk(relay_port_active, 1'b0);
      ser(2'h0, i[2:0]);
      wait_st(2'h1);
      chk({run_state, relay_speedup, motor_drive}, 4'h7);
      speed_rated <= 1'b1;
      wait_st(2'h2);
      chk({run_state, relay_rated_no, relay_rated_nc}, 4'ha);
      ser(2'h1, i[2:0]);
      speed_rated <= 1'b0;
      wait_st(2'h3);
      chk({relay_brake, brake_drive}, 2'h3);
      tick(3);
      chk(vent_valve, 1'b1);
      to_idle;
      tick(55);
      chk(vent_valve, 1'b0);
    end
    $display("serial test done");
    cmd_source <= 3'h1;
    want[0] <= 1'b1;
    tick(20);
    chk(relay_port_active, 1'b1);
    ser(2'h0, 3'h1);
    tick(6);
    chk(run_state, 2'h0);
    want[0] <= 1'b0;
    cmd_source <= 3'h2;
    want[5] <= 1'b1;
    tick(20);
    chk(rotation_hold, 1'b1);
    ser(2'h0, 3'h2);
    tick(8);
    chk({start_pending, run_state}, 3'h4);
    want[4] <= 1'b1;
    wait_st(2'h1);
    chk(run_state, 2'h1);
    want[4] <= 1'b0;
    wait_st(2'h3);
    chk(run_state, 2'h3);
    want[4] <= 1'b1;
    tick(20);
    chk(run_state, 2'h3);
    ser(2'h0, 3'h2);
    wait_st(2'h1);
    chk(run_state, 2'h1);
    ser(2'h1, 3'h2);
    to_idle;
    want[5] <= 1'b0;
    $display("interlock test done");
    cmd_source <= 3'h3;
    want[2] <= 1'b1;
    tick(20);
    want[1] <= 1'b1;
    tick(20);
    want[1] <= 1'b0;
    tick(20);
    chk(run_state, 2'h0);
    cmd_source <= 3'h5;
    tick(2);
    chk(relay_port_active, 1'b1);
    want[1] <= 1'b1;
    tick(20);
    want[1] <= 1'b0;
    wait_st(2'h1);
    chk(run_state, 2'h1);
    want[2] <= 1'b0;
    wait_st(2'h3);
    chk(run_state, 2'h3);
    to_idle;
    start_level_mode <= 1'b1;
    want[1] <= 1'b1;
    wait_st(2'h1);
    chk(run_state, 2'h1);
    want[1] <= 1'b0;
    wait_st(2'h3);
    chk(run_state, 2'h3);
    to_idle;
    $display("contact test done");
    fault_det <= 1'b1;
    tick(3);
    chk({relay_fault_no, relay_fault_nc}, 2'h2);
    fault_det <= 1'b0;
    cmd_source <= 3'h4;
    tick(3);
    chk({relay_fault_no, fault_latched}, 2'h3);
    ser(2'h2, 3'h4);
    tick(3);
    chk({relay_fault_no, relay_fault_nc}, 2'h1);
    $display("fault test done");
    give_verdict;
  end
endmodule
